// [rtl/ufc_pkg.sv]
// package: register map, field layout and carrier types of the uart frame and baud unit
//------------------------------------------------------------------------------
// What this block does
// - size code selects 5, 6, 7, 8, 9 bits
// - clock polarity matters only in synchronous mode
// - polarity picks transmit and sample clock edges
// - divisor is 12 bits over two bytes
// - low byte write reloads prescaler at once
// - frames in flight may break on change
// - double speed drops ratio from 16 to 8
// - mode select: zero asynchronous, one synchronous
//------------------------------------------------------------------------------
package ufc_pkg;

  // structure sizes
  localparam int unsigned DATA_W     = 9;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BAUD_W     = 12;

  // register byte addresses on the bus
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_BAUD_HI = 8'h08;
  localparam logic [7:0] OFF_BAUD_LO = 8'h0C;
  localparam logic [7:0] OFF_TXDATA  = 8'h10;
  localparam logic [7:0] OFF_RXDATA  = 8'h14;

  // reset values: size code 011 selects 8-bit frames
  localparam logic [7:0] CTRL_RST    = 8'h06;
  localparam logic [3:0] BAUD_HI_RST = 4'h0;
  localparam logic [7:0] BAUD_LO_RST = 8'h00;

  // oversampling ratios and the derived last and middle counts
  localparam int unsigned RATIO_NORM  = 16;
  localparam int unsigned RATIO_DBL   = 8;
  localparam logic [3:0]  OS_LAST_NRM = 4'(RATIO_NORM - 1);
  localparam logic [3:0]  OS_LAST_DBL = 4'(RATIO_DBL - 1);
  localparam logic [3:0]  OS_MID_NRM  = 4'(RATIO_NORM / 2 - 1);
  localparam logic [3:0]  OS_MID_DBL  = 4'(RATIO_DBL / 2 - 1);

  // ahb-lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  // control register, bit 0 upward: polarity, size[2:0], double speed, mode, enables
  typedef struct packed {
    logic       rx_en;
    logic       tx_en;
    logic       sync_mode_select;
    logic       double_speed_select;
    logic       char_size_top_bit;
    logic [1:0] char_size_low_bits;
    logic       sync_clock_polarity;
  } ufc_cfg_t;

  // status register, listed from bit 5 down to bit 0
  typedef struct packed {
    logic tx_busy;
    logic fifo_full;
    logic fifo_empty;
    logic rx_overrun;
    logic rx_frame_error;
    logic rx_ready;
  } ufc_status_t;

  // latched address phase of one bus transfer
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       word;
    logic [7:0] addr;
  } ufc_ahb_req_t;

endpackage

// [rtl/ufc_top.sv]
// design: transmit fifo and the uart frame size, clock polarity and baud unit
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------------------------
// transmit word fifo
//------------------------------------------------------------------------------
module ufc_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_ref_clk,   // system clock
  input  wire logic             i_reset_n,   // sync reset, low
  input  wire logic [WIDTH-1:0] i_wr_data,   // word to store
  input  wire logic             i_wr_valid,  // push request
  output logic                  o_wr_ready,  // room for a word
  output logic [WIDTH-1:0]      o_rd_data,   // oldest word
  output logic                  o_rd_valid,  // a word waits
  input  wire logic             i_rd_ready   // pop request
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // flags straight from the fill count, so full and empty never lie
  assign o_wr_ready = (count != (AW+1)'(DEPTH));
  assign o_rd_valid = (count != '0);
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = i_rd_ready & o_rd_valid;
  assign o_rd_data  = mem[rd_ptr];

  // storage, no reset needed on data
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  // pointers wrap at depth, any depth allowed
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // fill count
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      count <= '0;
    end else begin
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ufc_fifo

//------------------------------------------------------------------------------
// top: ahb-lite registers, prescaler, transmitter, receiver
//------------------------------------------------------------------------------
module ufc_top #(
  parameter int unsigned FIFO_DEPTH = ufc_pkg::FIFO_DEPTH
) (
  input  wire logic        i_ref_clk,              // 20 MHz system clock
  input  wire logic        i_reset_n,              // sync reset, low
  input  wire logic        i_hsel,                 // slave select
  input  wire logic [31:0] i_haddr,                // byte address
  input  wire logic [1:0]  i_htrans,               // transfer type
  input  wire logic        i_hwrite,               // write when high
  input  wire logic [2:0]  i_hsize,                // transfer size
  input  wire logic [31:0] i_hwdata,               // write data
  input  wire logic        i_hready,               // bus ready
  output logic [31:0]      o_hrdata,               // read data
  output logic             o_hreadyout,            // slave ready
  output logic             o_hresp,                // always okay
  input  wire logic        i_rxd,                  // serial in
  output logic             o_txd,                  // serial out
  output logic             o_sync_serial_clock,    // sync clock out
  output logic             o_sync_serial_clock_oe  // sync clock drive
);
  localparam int unsigned DW = ufc_pkg::DATA_W;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_state_t;

  ufc_pkg::ufc_cfg_t     cfg;
  ufc_pkg::ufc_status_t  status;
  ufc_pkg::ufc_ahb_req_t req;
  ufc_rx_state_t         rx_state;
  logic [3:0]            baud_div_hi;
  logic [7:0]            baud_div_lo;
  logic [11:0]           baud_div;
  logic [11:0]           presc_cnt;
  logic                  tick;
  logic                  stall;
  logic                  done;
  logic                  wr;
  logic                  wr_ctrl;
  logic                  wr_hi;
  logic                  wr_lo;
  logic                  wr_tx;
  logic                  rd_rx;
  logic [31:0]           rd_val;
  logic                  fifo_wr_ready;
  logic [DW-1:0]         fifo_rd_data;
  logic                  fifo_rd_valid;
  logic                  fifo_rd_ready;
  logic                  is_sync;
  logic                  pol;
  logic [3:0]            os_last;
  logic [3:0]            os_mid;
  logic [3:0]            tx_os;
  logic [3:0]            rx_os;
  logic                  clk_rise;
  logic                  clk_fall;
  logic                  tx_step;
  logic                  rx_samp;
  logic [3:0]            nbits;
  logic [10:0]           tx_sh;
  logic [3:0]            tx_left;
  logic                  rxd_meta;
  logic                  rxd_s;
  logic [3:0]            rx_cnt;
  logic [DW-1:0]         rx_sh;
  logic [DW-1:0]         rx_data;
  logic                  rx_done;
  logic                  rx_ready;
  logic                  rx_frame_error;
  logic                  rx_overrun;

  //----------------------------------------------------------------------------
  // bus slave
  //----------------------------------------------------------------------------
  // every transfer takes at least one wait state so all bus outputs come from flops
  assign stall   = req.write && (req.addr == ufc_pkg::OFF_TXDATA) && !fifo_wr_ready;
  assign done    = req.valid && !stall;
  assign wr      = done && req.write && req.word;
  assign wr_ctrl = wr && (req.addr == ufc_pkg::OFF_CTRL);
  assign wr_hi   = wr && (req.addr == ufc_pkg::OFF_BAUD_HI);
  assign wr_lo   = wr && (req.addr == ufc_pkg::OFF_BAUD_LO);
  assign wr_tx   = wr && (req.addr == ufc_pkg::OFF_TXDATA);
  assign rd_rx   = done && !req.write && (req.addr == ufc_pkg::OFF_RXDATA);

  // address phase capture, only while the bus is ready
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      req <= '0;
    end else if (i_hsel && i_htrans[1] && i_hready) begin
      req.valid <= 1'b1;
      req.write <= i_hwrite;
      req.word  <= (i_hsize == ufc_pkg::HSIZE_WORD);
      req.addr  <= i_haddr[7:0];
    end else if (done) begin
      req.valid <= 1'b0;
    end
  end

  // ready drops for the data phase, held low while a TXDATA write finds the fifo full
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= ufc_pkg::HRESP_OKAY;
    end else if (i_hsel && i_htrans[1] && i_hready) begin
      o_hreadyout <= 1'b0;
    end else if (done) begin
      o_hreadyout <= 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_val = '0;
    case (req.addr)
      ufc_pkg::OFF_CTRL:    rd_val[7:0]    = cfg;
      ufc_pkg::OFF_STATUS:  rd_val[5:0]    = status;
      ufc_pkg::OFF_BAUD_HI: rd_val[3:0]    = baud_div_hi;
      ufc_pkg::OFF_BAUD_LO: rd_val[7:0]    = baud_div_lo;
      ufc_pkg::OFF_RXDATA:  rd_val[DW-1:0] = rx_data;
      default:              rd_val         = '0;
    endcase
  end

  // read data registered at the end of the wait state
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_hrdata <= '0;
    end else if (done && !req.write) begin
      o_hrdata <= rd_val;
    end
  end

  //----------------------------------------------------------------------------
  // configuration and divisor registers
  //----------------------------------------------------------------------------
  // control register
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cfg <= ufc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      cfg <= ufc_pkg::ufc_cfg_t'(i_hwdata[7:0]);
    end
  end

  // divisor bytes; upper high-byte bits are not stored at all
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      baud_div_hi <= ufc_pkg::BAUD_HI_RST;
      baud_div_lo <= ufc_pkg::BAUD_LO_RST;
    end else begin
      if (wr_hi) begin
        baud_div_hi <= i_hwdata[3:0];
      end
      if (wr_lo) begin
        baud_div_lo <= i_hwdata[7:0];
      end
    end
  end
  assign baud_div = {baud_div_hi, baud_div_lo};

  //----------------------------------------------------------------------------
  // baud prescaler and bit-rate enables
  //----------------------------------------------------------------------------
  // tick once every divisor+1 clocks; frames in flight are not guarded
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      presc_cnt <= '0;
    end else if (wr_lo) begin
      presc_cnt <= {baud_div_hi, i_hwdata[7:0]};
    end else if (presc_cnt == '0) begin
      presc_cnt <= baud_div;
    end else begin
      presc_cnt <= presc_cnt - 12'h001;
    end
  end
  assign tick = (presc_cnt == '0) && !wr_lo;

  // mode decode; polarity is forced off outside synchronous mode
  assign is_sync = cfg.sync_mode_select;
  assign pol     = cfg.sync_clock_polarity && is_sync;
  assign os_last = cfg.double_speed_select ? ufc_pkg::OS_LAST_DBL
                                           : ufc_pkg::OS_LAST_NRM;
  assign os_mid  = cfg.double_speed_select ? ufc_pkg::OS_MID_DBL
                                           : ufc_pkg::OS_MID_NRM;

  // free oversampling count for the transmitter; >= copes with a ratio change
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || is_sync) begin
      tx_os <= '0;
    end else if (tick) begin
      tx_os <= (tx_os >= os_last) ? 4'h0 : tx_os + 4'h1;
    end
  end

  // synchronous clock: toggles on each tick, driven only in sync mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || !is_sync) begin
      o_sync_serial_clock <= 1'b0;
    end else if (tick) begin
      o_sync_serial_clock <= ~o_sync_serial_clock;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_sync_serial_clock_oe <= 1'b0;
    end else begin
      o_sync_serial_clock_oe <= is_sync;
    end
  end

  assign clk_rise = is_sync && tick && !o_sync_serial_clock;
  assign clk_fall = is_sync && tick && o_sync_serial_clock;
  // output changes on one edge, input sampled on the other
  assign tx_step  = is_sync ? (pol ? clk_fall : clk_rise)
                            : (tick && (tx_os == os_last));
  assign rx_samp  = is_sync ? (pol ? clk_rise : clk_fall)
                            : (tick && (rx_os == os_mid));

  // data bits per character; reserved codes fall back to eight
  always_comb begin
    case ({cfg.char_size_top_bit, cfg.char_size_low_bits})
      3'h0:    nbits = 4'h5;
      3'h1:    nbits = 4'h6;
      3'h2:    nbits = 4'h7;
      3'h3:    nbits = 4'h8;
      3'h7:    nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end

  //----------------------------------------------------------------------------
  // transmitter
  //----------------------------------------------------------------------------
  ufc_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) ufc_fifo_inst (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_wr_data  (i_hwdata[DW-1:0]),
    .i_wr_valid (wr_tx),
    .o_wr_ready (fifo_wr_ready),
    .o_rd_data  (fifo_rd_data),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready)
  );

  assign fifo_rd_ready = tx_step && (tx_left == '0) && cfg.tx_en;

  // start bit goes out on load; unused data bits padded with ones act as stop
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      tx_sh   <= '1;
      tx_left <= '0;
      o_txd   <= 1'b1;
    end else if (tx_step) begin
      if (tx_left != '0) begin
        o_txd   <= tx_sh[0];
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
      end else if (fifo_rd_valid && cfg.tx_en) begin
        o_txd   <= 1'b0;
        tx_sh   <= {2'b11, fifo_rd_data | (9'h1FF << nbits)};
        tx_left <= nbits + 4'h1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // receiver
  //----------------------------------------------------------------------------
  // two-flop synchroniser on the pin
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
    end else begin
      rxd_meta <= i_rxd;
      rxd_s    <= rxd_meta;
    end
  end

  // oversampling phase restarts at each start edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || (rx_state == RX_IDLE)) begin
      rx_os <= '0;
    end else if (tick) begin
      rx_os <= (rx_os >= os_last) ? 4'h0 : rx_os + 4'h1;
    end
  end

  // frame walk; sync mode has no start check because the clock aligns it
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n || !cfg.rx_en) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_sh    <= '0;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (!rxd_s && (is_sync ? rx_samp : tick)) begin
            rx_state <= is_sync ? RX_DATA : RX_START;
            rx_cnt   <= '0;
            rx_sh    <= '0;
          end
        end
        RX_START: begin
          if (rx_samp) begin
            rx_state <= rxd_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_sh[rx_cnt] <= rxd_s;
            rx_cnt        <= rx_cnt + 4'h1;
            if (rx_cnt == nbits - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_samp) begin
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end
  assign rx_done = (rx_state == RX_STOP) && rx_samp;

  // received word and flags; a new frame wins over a read in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rx_data        <= '0;
      rx_ready       <= 1'b0;
      rx_frame_error <= 1'b0;
      rx_overrun     <= 1'b0;
    end else if (rx_done) begin
      rx_data        <= rx_sh;
      rx_ready       <= 1'b1;
      rx_frame_error <= !rxd_s;
      rx_overrun     <= rx_ready && !rd_rx;
    end else if (rd_rx) begin
      rx_ready       <= 1'b0;
      rx_overrun     <= 1'b0;
    end
  end

  // status assembled in one place so each field has a single driver
  always_comb begin
    status.rx_ready       = rx_ready;
    status.rx_frame_error = rx_frame_error;
    status.rx_overrun     = rx_overrun;
    status.tx_busy    = (tx_left != '0);
    status.fifo_full  = !fifo_wr_ready;
    status.fifo_empty = !fifo_rd_valid;
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  a_low_reload: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_lo |=> (presc_cnt == baud_div))
    else $error("low byte write did not reload prescaler");

  a_high_no_reload: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_hi && presc_cnt != 12'h000) |=> (presc_cnt == $past(presc_cnt) - 12'h001))
    else $error("high byte write disturbed prescaler");

  a_nine_bit_frame: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (fifo_rd_ready && fifo_rd_valid && cfg.char_size_top_bit
     && cfg.char_size_low_bits == 2'h3) |=> (tx_left == 4'hA) && !o_txd)
    else $error("nine bit frame length wrong");

  a_five_bit_frame: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (fifo_rd_ready && fifo_rd_valid && !cfg.char_size_top_bit
     && cfg.char_size_low_bits == 2'h0) |=> (tx_left == 4'h6) && !o_txd)
    else $error("five bit frame length or start bit wrong");

  a_double_ratio: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!is_sync && cfg.double_speed_select && tick) |=> (tx_os <= 4'h7))
    else $error("double speed oversampling count passed eight");

  a_async_no_clock: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !is_sync |=> !o_sync_serial_clock && !o_sync_serial_clock_oe)
    else $error("sync clock active in asynchronous mode");

  a_tx_edge_pol: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (is_sync && $past(is_sync) && !cfg.sync_clock_polarity
     && $past(cfg.sync_clock_polarity) == 1'b0 && o_txd != $past(o_txd))
    |-> (o_sync_serial_clock && !$past(o_sync_serial_clock)))
    else $error("transmit data changed off the rising clock edge");

  a_high_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (done && !req.write && req.addr == ufc_pkg::OFF_BAUD_HI) |=> (o_hrdata[31:4] == 28'h0))
    else $error("reserved divisor bits read nonzero");

  a_div_reset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> (baud_div == 12'h000))
    else $error("divisor not zero after reset");

  a_fifo_stall: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (req.valid && stall) |=> !o_hreadyout)
    else $error("full fifo write not stalled");
endmodule // ufc_top

`default_nettype wire

// [tb/ufc_node.sv]
// remote serial node: decodes frames on the transmit line and sends frames on the receive line
`timescale 1ns/1ps
`default_nettype none
module ufc_node (
  input  wire logic i_ref_clk, // system clock
  input  wire logic i_txd,     // line from the unit
  output var logic  o_rxd = 1'b1 // line to the unit, idle high
);
  int         bit_clks = 16; // clocks a bit
  int         nbits    = 8;  // data bits a frame
  logic [8:0] got[$];        // words taken
  logic [8:0] w;             // word being built

  // sample each bit at its middle; a low stop bit is logged as 1FF
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (bit_clks / 2) @(posedge i_ref_clk);
      w = '0;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge i_ref_clk);
        w[i] = i_txd;
      end
      repeat (bit_clks) @(posedge i_ref_clk);
      got.push_back(i_txd ? w : 9'h1FF);
    end
  end

  // start low, data lsb first, stop high; the line idles high between frames
  task automatic send(input logic [8:0] d);
    @(posedge i_ref_clk);
    o_rxd <= 1'b0;
    for (int i = 0; i <= nbits + 1; i++) begin
      repeat (bit_clks) @(posedge i_ref_clk);
      o_rxd <= (i < nbits) ? d[i] : 1'b1;
    end
  endtask
endmodule // ufc_node
`default_nettype wire

// [tb/ufc_tb.sv]
// testbench: register, frame size, fifo, receive and sync clock scenarios
`timescale 1ns/1ps
`default_nettype none
module usart_frame_size_baud_config_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, r;
  logic        hrdy, hresp, txd, rxd, sck, sck_oe;
  logic        mon = 1'b0;
  logic        pol = 1'b0;
  logic        ptx = 1'b1;
  logic        pck = 1'b0;
  int          mismatches = 0;
  int          checks = 0;
  int          bad = 0;
  int          edges = 0;

  // 20 MHz clock
  initial forever #25 clk = ~clk;

  ufc_top ufc_top_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_rxd(rxd), .o_txd(txd),
    .o_sync_serial_clock(sck), .o_sync_serial_clock_oe(sck_oe));
  ufc_node ufc_node_inst (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));

  // in sync mode txd may move only together with the active clock edge
  always @(posedge clk) begin
    if (mon && txd !== ptx) begin
      edges++;
      if (sck === pck || sck !== ~pol) bad++;
    end
    ptx <= txd;
    pck <= sck;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one single ahb-lite transfer; waits on hready, never on a cycle count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  task automatic take(input logic [8:0] e);
    int n;
    n = 0;
    while (ufc_node_inst.got.size() == 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check({23'h0, ufc_node_inst.got.pop_front()}, {23'h0, e});
  endtask

  task automatic t_reset();
    bus(0, ufc_pkg::OFF_CTRL, 0);
    check(r, 32'h06);
    check(hresp, 0);
    bus(0, ufc_pkg::OFF_BAUD_HI, 0);
    check(r, 32'h00);
    bus(0, ufc_pkg::OFF_BAUD_LO, 0);
    check(r, 32'h00);
    bus(1, ufc_pkg::OFF_BAUD_HI, 32'h0F); // upper bits kept zero
    bus(0, ufc_pkg::OFF_BAUD_HI, 0);
    check(r, 32'h0F);
    bus(1, 8'h20, 32'hFFFF_FFFF);
    bus(0, 8'h20, 0);
    check(r, 32'h00);
    $display("t_reset done");
  endtask

  task automatic t_sizes();
    logic [2:0] c;
    logic [8:0] d;
    bus(1, ufc_pkg::OFF_BAUD_HI, 0);
    bus(1, ufc_pkg::OFF_BAUD_LO, 32'h01); // reload at once, exact rate
    for (int i = 0; i < 5; i++) begin
      c = (i == 4) ? 3'h7 : 3'(i);
      ufc_node_inst.nbits = i + 5;
      ufc_node_inst.bit_clks = (i == 3) ? 32 : 16; // ratio 16 or 8 times 2
      d = 9'h055 & ((9'h1 << (i + 4)) - 9'h1); // top bit low shows a wrong count
      bus(1, ufc_pkg::OFF_CTRL, {24'h0, 2'b01, 1'b0, (i != 3), c[2], c[1:0], 1'b0});
      bus(1, ufc_pkg::OFF_TXDATA, {23'h0, d});
      take(d);
    end
    $display("t_sizes done");
  endtask

  task automatic t_fifo();
    bus(1, ufc_pkg::OFF_CTRL, 32'h16);
    for (int i = 0; i < 8; i++) bus(1, ufc_pkg::OFF_TXDATA, 32'h30 + i);
    bus(0, ufc_pkg::OFF_STATUS, 0);
    check(r & 32'h18, 32'h10);
    ufc_node_inst.nbits = 8;
    ufc_node_inst.bit_clks = 16;
    bus(1, ufc_pkg::OFF_CTRL, 32'h56);
    bus(1, ufc_pkg::OFF_TXDATA, 32'h38); // stalls until the first word leaves
    for (int i = 0; i < 9; i++) take(9'h30 + 9'(i));
    bus(0, ufc_pkg::OFF_STATUS, 0);
    check(r & 32'h18, 32'h08);
    $display("t_fifo done");
  endtask

  task automatic t_rx();
    bus(1, ufc_pkg::OFF_CTRL, 32'h96);
    ufc_node_inst.send(9'h0A3);
    repeat (8) @(posedge clk);
    bus(0, ufc_pkg::OFF_STATUS, 0);
    check(r & 32'h07, 32'h01); // ready, no frame error, no overrun
    bus(0, ufc_pkg::OFF_RXDATA, 0);
    check(r, 32'hA3);
    bus(0, ufc_pkg::OFF_STATUS, 0);
    check(r & 32'h01, 32'h00);
    $display("t_rx done");
  endtask

  task automatic t_sync();
    int n;
    for (int p = 0; p < 2; p++) begin
      pol = 1'(p);
      bus(1, ufc_pkg::OFF_CTRL, {24'h0, 7'h33, pol});
      repeat (2) @(posedge clk);
      mon = 1'b1;
      check(sck_oe, 1);
      bus(1, ufc_pkg::OFF_TXDATA, 32'h5A);
      n = 0;
      do begin
        bus(0, ufc_pkg::OFF_STATUS, 0);
        n++;
      end while ((r & 32'h28) != 32'h08 && n < 200);
      check(n < 200, 1);
      mon = 1'b0;
    end
    check(bad, 0);
    check(edges != 0, 1);
    bus(1, ufc_pkg::OFF_CTRL, 32'h56);
    repeat (2) @(posedge clk);
    check(sck_oe, 0);
    $display("t_sync done");
  endtask

  // reset for 6 cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sizes();
    t_fifo();
    t_rx();
    t_sync();
    conclude();
  end

  // watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule // usart_frame_size_baud_config_test
`default_nettype wire
